// [include/ebp_pkg.sv]
// Purpose: shared constants and types for the 8-bit pulse modulator
// Assumes: byte addresses on an AXI4-Lite bus, 32-bit data
// Notes:   fields sit in the low byte of each register, except the STATUS run and duty bits 8 and 9
package ebp_pkg;
	localparam int AW = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_SRC    = 8'h04;
	localparam logic [7:0] OFF_ROUTE  = 8'h08;
	localparam logic [7:0] OFF_PERIOD = 8'h0c;
	localparam logic [7:0] OFF_THRESH = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;

	// Control bit positions
	localparam int CTRL_RUN  = 0;
	localparam int CTRL_IEN  = 1;
	localparam int CTRL_TRIG = 2;
	localparam int CTRL_CMP  = 3;
	localparam int CTRL_POL  = 4;
	localparam int CTRL_SYNC = 5;
	// Source and routing field positions
	localparam int SRC_CLK   = 0;
	localparam int SRC_EN    = 4;
	localparam int RT_DUTY   = 0;
	localparam int RT_WRAP   = 4;
	// Status field positions
	localparam int ST_RUN    = 8;
	localparam int ST_DUTY   = 9;

	// Values after reset
	localparam logic [7:0] RST_PERIOD = 8'hff;
	localparam logic [7:0] RST_THRESH = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Clock synchronisation modes
	typedef enum logic [1:0] {
		SYNC_SYS,
		SYNC_DBL,
		SYNC_DIRECT,
		SYNC_NONE
	} ebp_sync_t;

	// Row bus routing: enable plus bus index
	typedef struct packed {
		logic       en;
		logic [1:0] bus;
	} ebp_route_t;

	// Software configuration
	typedef struct packed {
		logic       run;
		logic       irq_en;
		logic       irq_on_wrap;
		logic       cmp_le;
		logic       en_inv;
		ebp_sync_t  sync;
		logic [3:0] clk_sel;
		logic [3:0] en_sel;
		ebp_route_t duty_rt;
		ebp_route_t wrap_rt;
	} ebp_cfg_t;
endpackage

// [rtl/ebp_src_sel.sv]
// Purpose: picks the counting clock and count enable from 16 sources
// Assumes: all sources are asynchronous pins or foreign logic
// Notes:   counting clock is turned into a one-cycle tick on clk_i
`timescale 1ns/100ps
module ebp_src_sel (
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	input  wire logic [15:0]        clk_src_i,
	input  wire logic [15:0]        en_src_i,
	input  wire logic [3:0]         clk_sel_i,
	input  wire logic [3:0]         en_sel_i,
	input  wire ebp_pkg::ebp_sync_t sync_i,
	input  wire logic               en_inv_i,
	output logic                    tick_o,
	output logic                    cnt_en_o
);
	logic [15:0] clk_s1;
	logic [15:0] clk_s2;
	logic [15:0] en_s1;
	logic [15:0] en_s2;
	logic        sel_prev;
	wire logic   sel_clk;
	wire logic   is_direct;

	// Two-stage synchronisers; only the second stage is read
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			clk_s1   <= 16'h0000;
			clk_s2   <= 16'h0000;
			en_s1    <= 16'h0000;
			en_s2    <= 16'h0000;
			sel_prev <= 1'b0;
		end else begin
			clk_s1   <= clk_src_i;
			clk_s2   <= clk_s1;
			en_s1    <= en_src_i;
			en_s2    <= en_s1;
			sel_prev <= sel_clk;
		end
	end

	// Selection and edge detect
	assign sel_clk   = clk_s2[clk_sel_i];
	assign is_direct = (sync_i == ebp_pkg::SYNC_DIRECT);
	// Direct mode ignores the selector and counts every clk_i cycle
	assign tick_o    = is_direct | (sel_clk & ~sel_prev);
	// Other modes share one edge detector: only clk_i exists here
	assign cnt_en_o  = en_s2[en_sel_i] ^ en_inv_i;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_direct_tick: assert property (is_direct |-> tick_o)
		else $error("direct mode lost a tick");
	// A switch into direct mode ticks at once, so only edge-to-edge counts
	a_edge_tick: assert property (!is_direct && tick_o ##1 !is_direct
		|-> !tick_o)
		else $error("edge detector ticked twice in a row");
	c_direct: cover property (is_direct ##1 is_direct);
endmodule

// [rtl/ebp_core.sv]
// Purpose: down counter, reload, duty compare and wrap pulse
// Assumes: tick_i is a one-cycle enable of the counting clock
// Notes:   stopped state holds the count unless load_i loads it, and forces duty low
`timescale 1ns/100ps
module ebp_core (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       run_i,
	input  wire logic       tick_i,
	input  wire logic       cnt_en_i,
	input  wire logic       cmp_le_i,
	input  wire logic [7:0] period_i,
	input  wire logic [7:0] thresh_i,
	input  wire logic       load_i,
	input  wire logic [7:0] load_val_i,
	output logic [7:0]      count_o,
	output logic            duty_o,
	output logic            wrap_o
);
	wire logic cmp_now;
	wire logic at_zero;
	wire logic step;

	// Strict or inclusive compare of count against threshold
	function automatic logic duty_cmp(input logic le, input logic [7:0] c,
		input logic [7:0] t);
		duty_cmp = le ? (c <= t) : (c < t);
	endfunction

	assign cmp_now = duty_cmp(cmp_le_i, count_o, thresh_i);
	assign at_zero = (count_o == 8'h00);
	assign step    = run_i & tick_i & cnt_en_i;

	// Counter: P+1 ticks per period since zero is a counted state
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count_o <= ebp_pkg::RST_PERIOD;
		end else if (!run_i && load_i) begin
			count_o <= load_val_i;
		end else if (step && at_zero) begin
			count_o <= period_i;
		end else if (step) begin
			count_o <= count_o - 8'h01;
		end
	end

	// Duty shows last tick's compare; wrap marks the reload edge
	always_ff @(posedge clk_i) begin
		if (srst_i || !run_i) begin
			duty_o <= 1'b0;
			wrap_o <= 1'b0;
		end else begin
			wrap_o <= step & at_zero;
			if (tick_i) begin
				duty_o <= cmp_now;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_reload_wrap: assert property (step && at_zero |=>
		count_o == $past(period_i) && wrap_o)
		else $error("reload or wrap pulse missing");
	a_count_down: assert property (step && !at_zero |=>
		count_o == $past(count_o) - 8'h01)
		else $error("counter did not decrement");
	a_hold_count: assert property (run_i && !cnt_en_i |=>
		$stable(count_o))
		else $error("counter moved while disabled");
	a_duty_cmp: assert property (run_i && tick_i |=>
		duty_o == $past(cmp_now))
		else $error("duty does not follow compare");
	c_reload: cover property (step && at_zero ##1 wrap_o);
endmodule

// [rtl/ebp_top.sv]
// Purpose: 8-bit pulse modulator with AXI4-Lite register access
// Assumes: one clock clk_i, synchronous reset, sources are async pins
// Notes on behaviour
// - counting clock is chosen from sixteen sources.
// - count enable is chosen from sixteen sources.
// - active enable counts continuously; inactive enable holds the count.
// - duty bus routing selectable or off; interrupts unaffected.
// - duty output always reaches next block and analog clock muxes.
// - wrap pulse is an auxiliary output, off or on any row bus.
// - period is eight bits, any value 0 to 255.
// - output period equals stored period plus one counting clocks.
// - interrupt source is duty rising edge or terminal count.
// - interrupts pass only when the separate enable is set.
// - duty compare is strict less-than or less-or-equal.
// - first sync mode aligns the source to the system clock.
// - second sync mode aligns to the doubled system clock; here it uses the same two-stage clk_i synchroniser.
// - direct mode feeds the system clock, overriding the selector.
// - an unsynchronised mode exists for sleep or doubled clock; here it still goes through the two-stage clk_i synchroniser.
// - enable polarity selects active-high or active-low enable.
// - running counter decrements when enabled and reloads after zero.
// - period write loads the count when stopped, else at reload.
// - duty low while stopped, else compare shown one edge later.
// - wrap pulse is high at the reload edge.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module ebp_top (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic [15:0] clk_src_i,
	input  wire logic [15:0] en_src_i,
	output logic             duty_o,
	output logic [3:0]       row_bus_o,
	output logic             wrap_o,
	output logic             irq_o
);
	ebp_pkg::ebp_cfg_t cfg;
	logic [7:0]        period;
	logic [7:0]        thresh;
	logic [7:0]        aw_addr;
	logic [7:0]        w_data;
	logic              w_lane0;
	logic              duty_d;
	wire logic [7:0]   count;
	wire logic         core_duty;
	wire logic         core_wrap;
	wire logic         tick;
	wire logic         cnt_en;

	// Steers a one-bit signal onto one of four row buses
	// An unrouted signal or a low level leaves every bus low
	function automatic logic [3:0] route(input ebp_pkg::ebp_route_t r,
		input logic s);
		route = (r.en && s) ? 4'(4'h1 << r.bus) : 4'h0;
	endfunction

	// Register address decode for writes
	// Only exact word offsets match; anything else answers SLVERR
	wire logic wr_fire;
	wire logic wr_ctrl;
	wire logic wr_src;
	wire logic wr_route;
	wire logic wr_period;
	wire logic wr_thresh;
	wire logic wr_stat;
	wire logic wr_hit;
	wire logic per_load;
	// High for one cycle, after the later of AW and W is taken
	assign wr_fire   = !s_axi_awready_o && !s_axi_wready_o &&
		!s_axi_bvalid_o;
	assign wr_ctrl   = (aw_addr == ebp_pkg::OFF_CTRL);
	assign wr_src    = (aw_addr == ebp_pkg::OFF_SRC);
	assign wr_route  = (aw_addr == ebp_pkg::OFF_ROUTE);
	assign wr_period = (aw_addr == ebp_pkg::OFF_PERIOD);
	assign wr_thresh = (aw_addr == ebp_pkg::OFF_THRESH);
	assign wr_stat   = (aw_addr == ebp_pkg::OFF_STATUS);
	// STATUS counts as a hit: the write is answered OKAY and ignored
	assign wr_hit    = wr_ctrl | wr_src | wr_route | wr_period |
		wr_thresh | wr_stat;
	// Stopped period write also loads the counter
	assign per_load  = wr_fire && wr_period && w_lane0 && !cfg.run;

	// Read decode: unmapped reads give zero data and SLVERR
	logic [31:0] rd_word;
	logic        rd_hit;
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr_i == ebp_pkg::OFF_CTRL) begin
			rd_word[7:0] = {1'b0, cfg.sync, cfg.en_inv, cfg.cmp_le,
				cfg.irq_on_wrap, cfg.irq_en, cfg.run};
		end else if (s_axi_araddr_i == ebp_pkg::OFF_SRC) begin
			rd_word[7:0] = {cfg.en_sel, cfg.clk_sel};
		end else if (s_axi_araddr_i == ebp_pkg::OFF_ROUTE) begin
			rd_word[7:0] = {1'b0, cfg.wrap_rt, 1'b0, cfg.duty_rt};
		end else if (s_axi_araddr_i == ebp_pkg::OFF_PERIOD) begin
			rd_word[7:0] = period;
		end else if (s_axi_araddr_i == ebp_pkg::OFF_THRESH) begin
			rd_word[7:0] = thresh;
		end else if (s_axi_araddr_i == ebp_pkg::OFF_STATUS) begin
			// Count read has no side effect on the threshold
			rd_word[7:0]            = count;
			rd_word[ebp_pkg::ST_RUN]  = cfg.run;
			rd_word[ebp_pkg::ST_DUTY] = core_duty;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Write channels: address and data taken in either order
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= ebp_pkg::RESP_OKAY;
			aw_addr         <= 8'h00;
			w_data          <= 8'h00;
			w_lane0         <= 1'b0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				s_axi_awready_o <= 1'b0;
				aw_addr         <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				s_axi_wready_o <= 1'b0;
				w_data         <= s_axi_wdata_i[7:0];
				w_lane0        <= s_axi_wstrb_i[0];
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit ? ebp_pkg::RESP_OKAY :
					ebp_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// Read channel: one read in flight, answer one edge after address
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= ebp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_word;
			s_axi_rresp_o   <= rd_hit ? ebp_pkg::RESP_OKAY :
				ebp_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// Configuration registers; only byte lane 0 holds fields
	// A write with lane 0 strobe low is answered OKAY and changes nothing
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg    <= '0;
			period <= ebp_pkg::RST_PERIOD;
			thresh <= ebp_pkg::RST_THRESH;
		end else if (wr_fire && w_lane0) begin
			if (wr_ctrl) begin
				cfg.run         <= w_data[ebp_pkg::CTRL_RUN];
				cfg.irq_en      <= w_data[ebp_pkg::CTRL_IEN];
				cfg.irq_on_wrap <= w_data[ebp_pkg::CTRL_TRIG];
				cfg.cmp_le      <= w_data[ebp_pkg::CTRL_CMP];
				cfg.en_inv      <= w_data[ebp_pkg::CTRL_POL];
				cfg.sync <= ebp_pkg::ebp_sync_t'(
					w_data[ebp_pkg::CTRL_SYNC +: 2]);
			end
			if (wr_src) begin
				cfg.clk_sel <= w_data[ebp_pkg::SRC_CLK +: 4];
				cfg.en_sel  <= w_data[ebp_pkg::SRC_EN +: 4];
			end
			if (wr_route) begin
				cfg.duty_rt <= w_data[ebp_pkg::RT_DUTY +: 3];
				cfg.wrap_rt <= w_data[ebp_pkg::RT_WRAP +: 3];
			end
			if (wr_period) begin
				period <= w_data;
			end
			if (wr_thresh) begin
				// Unbuffered: takes effect on the next tick
				thresh <= w_data;
			end
		end
	end

	ebp_src_sel u_src (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.clk_src_i (clk_src_i),
		.en_src_i  (en_src_i),
		.clk_sel_i (cfg.clk_sel),
		.en_sel_i  (cfg.en_sel),
		.sync_i    (cfg.sync),
		.en_inv_i  (cfg.en_inv),
		.tick_o    (tick),
		.cnt_en_o  (cnt_en)
	);

	ebp_core u_core (
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.run_i      (cfg.run),
		.tick_i     (tick),
		.cnt_en_i   (cnt_en),
		.cmp_le_i   (cfg.cmp_le),
		.period_i   (period),
		.thresh_i   (thresh),
		.load_i     (per_load),
		.load_val_i (w_data),
		.count_o    (count),
		.duty_o     (core_duty),
		.wrap_o     (core_wrap)
	);

	// Pin stage: outputs registered, so all lag the core by one cycle
	// duty_d keeps the last core duty for the rising-edge interrupt
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			duty_o    <= 1'b0;
			duty_d    <= 1'b0;
			wrap_o    <= 1'b0;
			row_bus_o <= 4'h0;
			irq_o     <= 1'b0;
		end else begin
			duty_o    <= core_duty;
			duty_d    <= core_duty;
			wrap_o    <= core_wrap;
			row_bus_o <= route(cfg.duty_rt, core_duty) |
				route(cfg.wrap_rt, core_wrap);
			// Trigger picks the event; enable gates it independently
			irq_o <= cfg.irq_en && (cfg.irq_on_wrap ? core_wrap :
				(core_duty && !duty_d));
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_stop_duty_low: assert property (!cfg.run |=> ##1 !duty_o)
		else $error("duty high while stopped");
	a_irq_gated: assert property (irq_o |-> $past(cfg.irq_en))
		else $error("interrupt passed while disabled");
	a_irq_on_wrap: assert property (cfg.irq_en && cfg.irq_on_wrap &&
		core_wrap |=> irq_o)
		else $error("wrap interrupt missing");
	a_irq_on_rise: assert property (cfg.irq_en && !cfg.irq_on_wrap &&
		core_duty && !duty_d |=> irq_o)
		else $error("duty rise interrupt missing");
	a_route_off: assert property (!cfg.duty_rt.en && !cfg.wrap_rt.en
		|=> row_bus_o == 4'h0)
		else $error("row bus driven while unrouted");
	a_period_load: assert property (per_load |=>
		count == $past(w_data))
		else $error("stopped period write did not load count");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped before taken");
	// Handshake checks: answers hold and second requests wait
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped before taken");
	a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address accepted during answer");
	a_aw_refused: assert property (s_axi_bvalid_o |->
		!s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted during answer");
	// Pin stage checks: the duty and wrap pins are the core value one cycle on
	a_duty_pin: assert property (duty_o == $past(core_duty))
		else $error("duty pin does not follow core");
	a_wrap_pin: assert property (wrap_o == $past(core_wrap))
		else $error("wrap pin does not follow core");
	c_irq: cover property (irq_o);
	c_load: cover property (per_load);
	c_route: cover property (row_bus_o != 4'h0);
endmodule

// [testbench/ebp_src_model.sv]
// Purpose: far-side sources: free-running clocks and enable levels
// Assumes: source k runs at 2*(2+k%4) system clock periods
// Notes:   phase offset keeps source edges clear of clk_i edges
`timescale 1ns/100ps
module ebp_src_model (
	input  wire logic [15:0] en_lvl_i,
	output logic      [15:0] clk_src_o,
	output logic      [15:0] en_src_o
);
	// Enable levels come straight from the bench
	assign en_src_o = en_lvl_i;
	// Slow external clocks, never faster than half of clk_i
	for (genvar k = 0; k < 16; k++) begin : g_src
		logic c;
		initial begin
			c = 1'b0;
			#37;
			forever #(100 * (2 + k % 4)) c = ~c;
		end
		assign clk_src_o[k] = c;
	end
endmodule

// [testbench/eight_bit_pulse_modulator_tb.sv]
// Purpose: self-checking bench for the 8-bit pulse modulator
// Assumes: AXI4-Lite master tasks, free-running source model
// Notes:   windows between wrap pulses are checked against a model
`timescale 1ns/100ps
module eight_bit_pulse_modulator_tb;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  s_axi_awaddr_i = 8'h00;
	logic [7:0]  s_axi_araddr_i = 8'h00;
	logic        s_axi_awvalid_i = 1'b0;
	logic        s_axi_wvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0;
	logic        s_axi_rready_i = 1'b0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
	logic [31:0] s_axi_rdata_o, rd;
	logic [15:0] clk_src_i, en_src_i;
	logic [15:0] en_lvl = 16'hffff;
	logic        duty_o, wrap_o, irq_o;
	logic [3:0]  row_bus_o, erow;
	logic [7:0]  rt = 8'h00;
	logic        mon = 1'b0;
	logic        have = 1'b0;
	int          miscompares = 0;
	int          compares = 0;
	int          egap, ehi, eirq, cyc, hi, irqs, nwin;

	ebp_top ebp_top_i (.clk_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
		.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
		.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .clk_src_i,
		.en_src_i, .duty_o, .row_bus_o, .wrap_o, .irq_o);
	ebp_src_model ebp_src_model_i (.en_lvl_i(en_lvl), .clk_src_o(clk_src_i),
		.en_src_o(en_src_i));

	// System clock, 100 ns period
	initial begin
		forever #50 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Write: address and data offered together, released as taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wdata_i <= d;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (n < 100) begin
			@(posedge clk_i);
			n++;
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o) begin
				rsp = s_axi_bresp_o;
				s_axi_bready_i <= 1'b0;
				n = 1000;
			end
		end
		chk("write done", 1, n == 1000);
	endtask

	// Read and compare data and response
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		while (n < 100) begin
			@(posedge clk_i);
			n++;
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o) begin
				rd = s_axi_rdata_o;
				rsp = s_axi_rresp_o;
				s_axi_rready_i <= 1'b0;
				n = 1000;
			end
		end
		chk(nm, e, rd);
		chk("read resp", 32'(er), 32'(rsp));
	endtask

	// Model of one pulse cycle; counts start only after a full wrap
	always @(posedge clk_i) begin
		if (!mon) begin
			have = 1'b0;
			cyc = 0;
			hi = 0;
			irqs = 0;
		end else begin
			erow = 4'h0;
			if (rt[2]) erow[rt[1:0]] = duty_o;
			if (rt[6]) erow[rt[5:4]] = erow[rt[5:4]] | wrap_o;
			chk("row bus", 32'(erow), 32'(row_bus_o));
			cyc++;
			hi += duty_o;
			irqs += irq_o;
			if (wrap_o) begin
				if (have) begin
					chk("gap", egap, cyc);
					chk("high", ehi, hi);
					chk("irqs", eirq, irqs);
					nwin++;
				end
				have = 1'b1;
				cyc = 0;
				hi = 0;
				irqs = 0;
			end
		end
	end

	// Stop, configure, run three full windows, stop again
	task automatic run_case(input int p, thr, dv, input logic [7:0] src, c);
		int h;
		axw(ebp_pkg::OFF_CTRL, 32'h0);
		axw(ebp_pkg::OFF_PERIOD, 32'(p));
		axw(ebp_pkg::OFF_THRESH, 32'(thr));
		axw(ebp_pkg::OFF_SRC, 32'(src));
		axw(ebp_pkg::OFF_ROUTE, 32'(rt));
		h = c[3] ? thr + 1 : thr;
		if (h > p + 1) h = p + 1;
		egap = (p + 1) * dv;
		ehi = h * dv;
		eirq = !c[1] ? 0 : c[2] ? 1 : (h > 0 && h <= p);
		nwin = 0;
		axw(ebp_pkg::OFF_CTRL, 32'(c));
		mon <= 1'b1;
		for (int n = 0; n < 20000 && nwin < 3; n++) @(posedge clk_i);
		chk("windows", 1, nwin >= 3);
		mon <= 1'b0;
		axw(ebp_pkg::OFF_CTRL, 32'h0);
		// Core duty clears one edge after stop, the pin one edge later
		@(posedge clk_i);
		@(negedge clk_i);
		chk("duty stopped", 0, duty_o);
	endtask

	// Watchdog, well past the expected run length
	initial begin
		#6000000;
		miscompares++;
		end_of_test();
	end

	// Main sequence
	initial begin
		int p, thr, k;
		logic [7:0] c;
		void'($urandom(32'h26683d8d));
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		@(negedge clk_i);
		chk("duty reset", 0, duty_o);
		chk("irq reset", 0, irq_o);
		rchk("ctrl", ebp_pkg::OFF_CTRL, 0, ebp_pkg::RESP_OKAY);
		rchk("period", ebp_pkg::OFF_PERIOD, 32'hff, 2'h0);
		rchk("thresh", ebp_pkg::OFF_THRESH, 0, 2'h0);
		rchk("status", ebp_pkg::OFF_STATUS, 32'hff, 2'h0);
		rchk("unmapped", 8'h1c, 0, ebp_pkg::RESP_SLVERR);
		axw(8'h1c, 32'h5a);
		chk("unmapped wr", 32'(ebp_pkg::RESP_SLVERR), 32'(rsp));
		axw(ebp_pkg::OFF_PERIOD, 32'ha5);
		rchk("load", ebp_pkg::OFF_STATUS, 32'ha5, 2'h0);
		$display("test reset and registers done");
		// Every-cycle counting, all compare, trigger and enable combinations
		for (int i = 0; i < 8; i++) begin
			p = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(9, 1);
			thr = $urandom_range(p, 0);
			rt = 8'($urandom) & 8'h77;
			k = $urandom_range(15, 0);
			en_lvl <= 16'h1 << k;
			c = {1'b0, ebp_pkg::SYNC_DIRECT, 1'b0, i[0], i[1], i[2], 1'b1};
			run_case(p, thr, 1, {k[3:0], ~k[3:0]}, c);
		end
		$display("test direct mode done");
		// Edge-detected source clocks in the three other modes
		for (int m = 0; m < 4; m++) begin
			if (m == 2) continue;
			k = $urandom_range(15, 0);
			p = $urandom_range(15, 1);
			thr = $urandom_range(p, 0);
			rt = 8'($urandom) & 8'h77;
			en_lvl <= 16'h1 << k;
			c = {1'b0, m[1:0], 5'h0f};
			run_case(p, thr, 2 * (2 + k % 4), {k[3:0], k[3:0]}, c);
		end
		$display("test source clocks done");
		// Inactive enable holds the count; inverted polarity counts
		k = 5;
		en_lvl <= ~(16'h1 << k);
		axw(ebp_pkg::OFF_SRC, 32'h55);
		// Known count: stopped period write loads it, compare stays false
		axw(ebp_pkg::OFF_PERIOD, 32'h30);
		axw(ebp_pkg::OFF_THRESH, 32'h10);
		axw(ebp_pkg::OFF_CTRL, 32'h41);
		rchk("running", ebp_pkg::OFF_STATUS, 32'h130, 2'h0);
		repeat (20) @(posedge clk_i);
		rchk("held", ebp_pkg::OFF_STATUS, 32'h130, 2'h0);
		// Running period write must wait for a reload
		axw(ebp_pkg::OFF_PERIOD, 32'h05);
		rchk("no load", ebp_pkg::OFF_STATUS, 32'h130, 2'h0);
		axw(ebp_pkg::OFF_STATUS, 32'h0);
		chk("status wr", 32'(ebp_pkg::RESP_OKAY), 32'(rsp));
		// Lane 0 strobe low: answered, nothing stored
		s_axi_wstrb_i <= 4'h0;
		axw(ebp_pkg::OFF_THRESH, 32'hff);
		s_axi_wstrb_i <= 4'hf;
		rchk("lane off", ebp_pkg::OFF_THRESH, 32'h10, 2'h0);
		run_case(3, 2, 1, 8'h55, 8'h51);
		$display("test enable done");
		end_of_test();
	end
endmodule
